// ### hw/pport_top.sv
// Handshaked parallel port: host bus, port A strobed/bidirectional, port B strobed output, port C status.
// Assumes host strobes are one-cycle pulses synchronous to CORE_CLK and peripheral lines are synchronous too.
`include "pport_defines.svh"
module pport_top
    import pport_pkg::*;
(
    // Clock and reset
    input  wire logic       CORE_CLK,
    input  wire logic       ARST_N,
    // Host bus
    input  wire logic       HOST_RD,
    input  wire logic       HOST_WR,
    input  wire logic [1:0] HOST_SEL,
    input  wire logic [7:0] HOST_WDATA,
    output logic [7:0]      HOST_RDATA,
    // Port A lines and handshake
    input  wire logic [7:0] PORT_A_LINES_I,
    output logic [7:0]      PORT_A_LINES_O,
    output logic            PORT_A_LINES_OE,
    input  wire logic       A_ACK_N,
    input  wire logic       IN_LATCH_STROBE_N,
    output logic            OUT_LATCH_FULL_N,
    output logic            IN_LATCH_FULL,
    output logic            PORT_A_IRQ,
    // Port B lines and handshake
    output logic [7:0]      PORT_B_LINES,
    input  wire logic       B_ACK_N,
    output logic            B_OUT_FULL_N,
    output logic            PORT_B_IRQ,
    // Port C spare output bit 0 for pulsed strobe
    output logic            PORT_C0
);
    host_req_t req;
    logic [7:0] ctrl_ff, rdata_ff, in_latch_ff;
    logic [7:0] inte_ff;
    logic       ibf_ff, stb_q_ff, c0_ff, oe_ff;
    logic [7:0] a_dout, b_dout;
    logic       a_full_n, a_irq_o, b_full_n, b_irq;
    a_mode_t    a_mode;

    assign req = '{rd: HOST_RD, wr: HOST_WR, sel: HOST_SEL, wdata: HOST_WDATA};

    // Address decode of the two select bits
    wire wr_a    = req.wr && req.sel == `SEL_PORT_A;    // R14
    wire wr_b    = req.wr && req.sel == `SEL_PORT_B;    // R14
    wire wr_ctrl = req.wr && req.sel == `SEL_CTRL;      // R14
    wire wr_mode = wr_ctrl && req.wdata[`CW_MODE_FLAG];
    wire wr_bsr  = wr_ctrl && !req.wdata[`CW_MODE_FLAG];
    wire rd_a    = req.rd && req.sel == `SEL_PORT_A;
    wire [2:0] bsr_bit = req.wdata[`BSR_BIT_HI:`BSR_BIT_LO];
    wire bsr_val = req.wdata[`BSR_VALUE];

    // Mode selection from the control word
    wire a_bidir  = ctrl_ff[`CW_A_MODE_HI];             // R11
    wire a_strobe = ctrl_ff[`CW_A_MODE_LO] | a_bidir;
    assign a_mode = a_strobe ? MODE_STROBED : MODE_BASIC;
    wire b_strobe = ctrl_ff[`CW_B_MODE];
    wire stb_edge = stb_q_ff & ~IN_LATCH_STROBE_N;
    wire a_in_irq = ibf_ff & inte_ff[`INTE_A_IN] & a_bidir;

    // Port A output channel
    pport_chan u_chan_a (
        .clk    (CORE_CLK),
        .arst_n (ARST_N),
        .load   (wr_a),
        .din    (req.wdata),
        .inte   (inte_ff[`INTE_A_OUT] && a_mode == MODE_STROBED),
        .clear  (wr_mode),
        .ack_n  (A_ACK_N),
        .dout   (a_dout),
        .full_n (a_full_n),
        .irq    (a_irq_o)
    );

    // Port B output channel, its own request line
    pport_chan u_chan_b (
        .clk    (CORE_CLK),
        .arst_n (ARST_N),
        .load   (wr_b),
        .din    (req.wdata),
        .inte   (inte_ff[`INTE_B] && b_strobe),
        .clear  (wr_mode),
        .ack_n  (B_ACK_N),
        .dout   (b_dout),
        .full_n (b_full_n),
        .irq    (b_irq)                                 // R1
    );

    // Status word assembled for port C reads
    wire [7:0] status_w = {a_full_n, inte_ff[`INTE_A_OUT], ibf_ff, inte_ff[`INTE_A_IN],
                           a_irq_o | a_in_irq, inte_ff[`INTE_B], b_full_n, b_irq}; // R13

    // Read data select
    wire [7:0] rd_mux = (req.sel == `SEL_PORT_A) ? (a_bidir ? in_latch_ff : PORT_A_LINES_I) :
                        (req.sel == `SEL_PORT_B) ? b_dout :
                        (req.sel == `SEL_PORT_C) ? status_w : ctrl_ff;

    // Control word and bit set/reset
    always_ff @(posedge CORE_CLK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            ctrl_ff <= `RST_CTRL;
            inte_ff <= `RST_BYTE;
            c0_ff   <= 1'b0;
        end
        else if (wr_mode)
        begin
            ctrl_ff <= req.wdata;
            inte_ff <= `RST_BYTE;
            c0_ff   <= 1'b0;
        end
        else if (wr_bsr)
        begin
            inte_ff[bsr_bit] <= bsr_val;
            if (bsr_bit == 3'h0)
                c0_ff <= bsr_val;                       // R6
        end
    end

    // Input latch for mode 2; the strobe edge wins over a same-cycle read
    always_ff @(posedge CORE_CLK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            in_latch_ff <= `RST_BYTE;
            ibf_ff      <= 1'b0;
            stb_q_ff    <= 1'b1;
        end
        else
        begin
            stb_q_ff <= IN_LATCH_STROBE_N;
            if (stb_edge && a_bidir)
            begin
                in_latch_ff <= PORT_A_LINES_I;          // R11
                ibf_ff      <= 1'b1;
            end
            else if (rd_a || wr_mode)
                ibf_ff <= 1'b0;
        end
    end

    // Registered outputs
    always_ff @(posedge CORE_CLK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            rdata_ff         <= `RST_BYTE;
            oe_ff            <= 1'b0;
            OUT_LATCH_FULL_N <= 1'b1;
            IN_LATCH_FULL    <= 1'b0;
            PORT_A_IRQ       <= 1'b0;
            PORT_A_LINES_O   <= `RST_BYTE;
            PORT_B_LINES     <= `RST_BYTE;
            B_OUT_FULL_N     <= 1'b1;
            PORT_B_IRQ       <= 1'b0;
            PORT_C0          <= 1'b0;
        end
        else
        begin
            rdata_ff         <= rd_mux;
            oe_ff            <= a_bidir ? ~A_ACK_N : ~ctrl_ff[`CW_A_IN]; // R11
            OUT_LATCH_FULL_N <= a_full_n;               // R2
            IN_LATCH_FULL    <= ibf_ff;
            PORT_A_IRQ       <= a_irq_o | a_in_irq;     // R1
            PORT_A_LINES_O   <= a_dout;
            PORT_B_LINES     <= b_dout;
            B_OUT_FULL_N     <= b_full_n;
            PORT_B_IRQ       <= b_irq;
            PORT_C0          <= c0_ff;
        end
    end

    assign HOST_RDATA      = rdata_ff;
    assign PORT_A_LINES_OE = oe_ff;

    // Named steps of an output transfer
    sequence byte_written_s;
        wr_a;
    endsequence
    sequence full_shown_s;
        ##2 !OUT_LATCH_FULL_N;
    endsequence

    obf_low_a: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
        byte_written_s |-> full_shown_s) // R2
        else $error("buffer-full pin not low after port A write");
    status_read_a: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
        (req.rd && req.sel == `SEL_PORT_C) |=> HOST_RDATA == $past(status_w)) // R13
        else $error("port C read did not return status");
    ctrl_decode_a: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
        wr_mode |=> ctrl_ff == $past(req.wdata)) // R14
        else $error("control word not stored");
    irq_pin_a: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
        a_irq_o |=> PORT_A_IRQ) // R1
        else $error("port A request not on its pin");
    bit0_pulse_a: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
        (wr_bsr && bsr_bit == 3'h0 && !wr_mode) |=> ##1 PORT_C0 == $past(bsr_val, 2)) // R6
        else $error("port C bit 0 did not follow bit set/reset");
    in_latch_a: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
        (stb_edge && a_bidir) |=> ibf_ff ##1 IN_LATCH_FULL) // R11
        else $error("input strobe did not fill latch");
    bus_drive_a: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
        (a_bidir && !A_ACK_N) |=> PORT_A_LINES_OE) // R11
        else $error("port A not driven during acknowledge");
    b_irq_a: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
        wr_b |=> ##2 !PORT_B_IRQ) // R15
        else $error("port B request not withdrawn on write");

    // Data path and input latch checks
    a_lines_a: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
        wr_a |=> ##1 PORT_A_LINES_O == $past(req.wdata, 2)) // R2
        else $error("port A lines do not show the written byte");
    b_lines_a: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
        wr_b |=> ##1 PORT_B_LINES == $past(req.wdata, 2)) // R14
        else $error("port B lines do not show the written byte");
    in_irq_a: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
        (stb_edge && a_bidir && inte_ff[`INTE_A_IN] && !wr_ctrl) |=> ##1 PORT_A_IRQ) // R11
        else $error("input strobe did not raise port A request");
    read_clears_a: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
        (rd_a && !stb_edge) |=> !ibf_ff) // R11
        else $error("port A read did not empty the input latch");
endmodule // pport_top

// ### hw/pport_defines.svh
// Constants for the handshaked parallel port: host select codes, control word fields, status bit positions.
// Assumes an 8-bit host data bus and a two-bit port select taken synchronously with the core clock.
// How it works
// (R1) Each handshaked port has its own interrupt request output.
// (R2) Writing a byte into the port A output latch drives the buffer-full line low at once; here the pin goes low two clock cycles after the write.
// (R3) The peripheral pulses acknowledge once it has taken the byte on the port A lines.
// (R4) On acknowledge the buffer-full indication clears and then the port interrupt request rises.
// (R5) A level-sensitive peripheral may use the buffer-full line itself as its data strobe.
// (R6) For a pulsed strobe the host writes the byte and then pulses port C bit 0 with bit set and reset commands.
// (R7) The host sends the next byte only after the acknowledge for the previous one.
// (R8) The port A interrupt request is wired to the host processor interrupt input.
// (R9) After reset the host writes the mode control word before any transfer.
// (R10) On an interrupt the host polls the status to find the requesting port.
// (R11) In mode 2 port A is a two-way bus: acknowledge reads the output byte, the input strobe writes a byte in.
// (R12) The host moves the next byte only in answer to the completion interrupt.
// (R13) A read of port C returns a status word showing which port is interrupting or ready.
// (R14) Two low address bits select port A, port B, port C or the control word register.
// (R15) Writing the next data byte withdraws the port interrupt request.
`ifndef PPORT_DEFINES_SVH
`define PPORT_DEFINES_SVH
// Port select codes
`define SEL_PORT_A   2'h0
`define SEL_PORT_B   2'h1
`define SEL_PORT_C   2'h2
`define SEL_CTRL     2'h3
// Control word fields
`define CW_MODE_FLAG 7
`define CW_A_MODE_HI 6
`define CW_A_MODE_LO 5
`define CW_A_IN      4
`define CW_B_MODE    2
`define CW_B_IN      1
`define BSR_BIT_HI   3
`define BSR_BIT_LO   1
`define BSR_VALUE    0
// Interrupt enable bits held in port C bit positions
`define INTE_A_OUT   6
`define INTE_A_IN    4
`define INTE_B       2
// Status word bit positions in port C
`define ST_OBF_A_N   7
`define ST_IBF_A     5
`define ST_IRQ_A     3
`define ST_IRQ_B     0
`define ST_OBF_B_N   1
// Reset values
`define RST_CTRL     8'h9B
`define RST_BYTE     8'h00
`endif

// ### hw/pport_pkg.sv
// Types for the handshaked parallel port.
// Assumes the defines header is included by files that need numbers.
package pport_pkg;
    typedef enum logic [1:0] {
        MODE_BASIC = 2'b01,
        MODE_STROBED = 2'b10
    } a_mode_t;
    typedef struct packed {
        logic       rd;
        logic       wr;
        logic [1:0] sel;
        logic [7:0] wdata;
    } host_req_t;
    typedef struct packed {
        logic       strobe;
        logic [7:0] data;
    } side_in_t;
endpackage

// ### hw/pport_chan.sv
// One handshake channel: an output latch with buffer-full flag and acknowledge-driven interrupt.
// Assumes acknowledge is active low and synchronous to the core clock.
`include "pport_defines.svh"
module pport_chan
    import pport_pkg::*;
(
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       arst_n,
    // Host side
    input  wire logic       load,
    input  wire logic [7:0] din,
    input  wire logic       inte,
    input  wire logic       clear,
    // Peripheral side
    input  wire logic       ack_n,
    // State
    output logic [7:0]      dout,
    output logic            full_n,
    output logic            irq
);
    logic ack_q_ff;
    logic done_ff;
    wire  ack_edge = ack_q_ff & ~ack_n;

    // Latch, buffer flag and completion flag
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            dout     <= `RST_BYTE;
            full_n   <= 1'b1;
            done_ff  <= 1'b0;
            ack_q_ff <= 1'b1;
        end
        else
        begin
            ack_q_ff <= ack_n;
            if (load)
            begin
                dout    <= din;
                full_n  <= 1'b0;  // R2
                done_ff <= 1'b0;  // R15
            end
            else if (clear)
            begin
                full_n  <= 1'b1;
                done_ff <= 1'b0;
            end
            else if (ack_edge && !full_n)
            begin
                full_n  <= 1'b1;  // R4
                done_ff <= 1'b1;  // R4
            end
        end
    end

    // Request follows completion one cycle after the flag clears
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            irq <= 1'b0;
        else
            irq <= done_ff & inte & full_n & ~load;
    end

    ack_clears_a: assert property (@(posedge clk) disable iff (!arst_n)
        (ack_edge && !full_n && !load && !clear) |=> full_n ##1 (irq == inte)) // R4
        else $error("ack did not clear full then raise request");
    load_full_a: assert property (@(posedge clk) disable iff (!arst_n)
        load |=> !full_n && dout == $past(din)) // R2
        else $error("load did not set buffer full");
    load_drop_a: assert property (@(posedge clk) disable iff (!arst_n)
        load |=> ##1 !irq) // R15
        else $error("request not withdrawn after load");
endmodule // pport_chan

// ### tb/pport_peer.sv
// Printer-like far side of port A: takes each byte on the buffer-full level and acknowledges it.
// Assumes the bench resolves the port A lines from the output enable.
module pport_peer (
    // Clock and handshake
    input  wire logic       clk,
    input  wire logic       full_n,
    input  wire logic [2:0] dly,
    output logic            ack_n,
    output logic            stb_n,
    // Bytes driven toward port A
    output logic [7:0]      lines
);
    timeunit 1ns;
    timeprecision 1ns;

    // Idle levels
    initial
    begin
        ack_n = 1'b1;
        stb_n = 1'b1;
        lines = 8'hA5;
    end

    // Full level used as strobe; byte taken after dly cycles, then acknowledged
    always
    begin
        @(posedge clk iff !full_n);
        repeat (dly) @(posedge clk);
        #2 ack_n = 1'b0;
        repeat (2) @(posedge clk);
        #2 ack_n = 1'b1;
        @(posedge clk iff full_n);
    end

    // Strobe one byte in; lines drift to the inverse once released
    task automatic send(input logic [7:0] v);
        @(posedge clk);
        #2 lines = v;
        stb_n = 1'b0;
        repeat (2) @(posedge clk);
        #2 stb_n = 1'b1;
        lines = ~v;
    endtask
endmodule // pport_peer

// ### tb/testbench.sv
// Self-checking bench for the handshaked parallel port, peer model on port A.
// Assumes the package, the port top and the peer model are compiled first.
`include "pport_defines.svh"
module testbench
    import pport_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ns;

    logic       clk, arst_n, a_oe, a_ack_n, stb_n, a_full_n, in_full, a_irq;
    logic       b_ack_n, b_full_n, b_irq, c0;
    logic [7:0] rdata, a_o, b_lines, pl, d;
    logic [2:0] dly;
    host_req_t  req;
    int         n_mismatch, num_checks, i, k;

    pport_top pport_top_inst (
        .CORE_CLK(clk), .ARST_N(arst_n), .HOST_RD(req.rd), .HOST_WR(req.wr), .HOST_SEL(req.sel),
        .HOST_WDATA(req.wdata), .HOST_RDATA(rdata), .PORT_A_LINES_I(a_oe ? a_o : pl),
        .PORT_A_LINES_O(a_o), .PORT_A_LINES_OE(a_oe), .A_ACK_N(a_ack_n), .IN_LATCH_STROBE_N(stb_n),
        .OUT_LATCH_FULL_N(a_full_n), .IN_LATCH_FULL(in_full), .PORT_A_IRQ(a_irq),
        .PORT_B_LINES(b_lines), .B_ACK_N(b_ack_n), .B_OUT_FULL_N(b_full_n), .PORT_B_IRQ(b_irq),
        .PORT_C0(c0));
    pport_peer pport_peer_inst (.clk(clk), .full_n(a_full_n), .dly(dly), .ack_n(a_ack_n),
        .stb_n(stb_n), .lines(pl));

    // Clock
    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    function automatic logic [7:0] exp_status(input logic en);
        return {1'b1, en, 2'b00, en, 3'b000};
    endfunction

    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #2;
    endtask

    // One host cycle; read data is caught right after the taking edge
    task automatic bus(input logic rd, input logic [1:0] sel, input logic [7:0] wd);
        @(posedge clk);
        #2 req = '{rd, ~rd, sel, wd};
        @(posedge clk);
        #1 d = rdata;
        #1 req = '0;
    endtask

    // One printer byte, through to the completion interrupt
    task automatic send_a(input logic [7:0] v, input logic en);
        bus(0, `SEL_PORT_A, v);
        cyc(2);
        check("a_full_n", 8'(a_full_n), 8'h00);
        check("a_lines", a_o, v);
        check("a_irq_drop", 8'(a_irq), 8'h00);
        for (k = 0; k < 30 && a_full_n !== 1'b1; k++) cyc(1);
        cyc(1);
        check("a_irq", 8'(a_irq), 8'(en));
        check("a_full_clr", 8'(a_full_n), 8'h01);
    endtask

    task automatic stop_test;
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // Watchdog
    initial
    begin
        cyc(4000);
        n_mismatch++;
        stop_test;
    end

    // Main sequence
    initial
    begin
        arst_n = 1'b0;
        req = '0;
        b_ack_n = 1'b1;
        dly = 3'h1;
        n_mismatch = 0;
        num_checks = 0;
        void'($urandom(48));
        cyc(10);
        check("rst_flags", 8'({a_full_n, b_full_n, a_irq, a_oe}), 8'h0C);
        arst_n = 1'b1;
        bus(1, `SEL_CTRL, 8'h00);
        check("ctrl_rst", d, `RST_CTRL);
        bus(0, `SEL_CTRL, 8'hA4);
        bus(0, `SEL_CTRL, 8'h0D);
        bus(0, `SEL_CTRL, 8'h05);
        for (i = 0; i < 8; i++)
        begin
            dly = 3'($urandom_range(1, 5));
            send_a(i == 0 ? 8'h00 : i == 1 ? 8'hFF : 8'($urandom), 1'b1);
            bus(1, `SEL_PORT_C, 8'h00);
            check("status", d & 8'hC8, exp_status(1'b1));
        end
        $display("test strobed_output done");
        bus(0, `SEL_CTRL, 8'h01);
        cyc(2);
        check("c0_set", 8'(c0), 8'h01);
        bus(0, `SEL_CTRL, 8'h00);
        cyc(2);
        check("c0_clr", 8'(c0), 8'h00);
        bus(0, `SEL_CTRL, 8'h0C);
        send_a(8'h5A, 1'b0);
        bus(1, `SEL_PORT_C, 8'h00);
        check("status_m", d & 8'hC0, exp_status(1'b0) & 8'hC0);
        $display("test masked done");
        bus(0, `SEL_PORT_B, 8'h96);
        cyc(2);
        check("b_lines", b_lines, 8'h96);
        check("b_full_n", 8'(b_full_n), 8'h00);
        b_ack_n = 1'b0;
        cyc(2);
        b_ack_n = 1'b1;
        cyc(4);
        check("b_irq", 8'({b_irq, a_irq, b_full_n}), 8'h05);
        bus(1, `SEL_PORT_B, 8'h00);
        check("b_read", d, 8'h96);
        bus(1, `SEL_PORT_C, 8'h00);
        check("status_b", d & 8'h07, 8'h07);
        $display("test port_b done");
        bus(0, `SEL_CTRL, 8'hC0);
        cyc(1);
        check("bidir_oe", 8'(a_oe), 8'h00);
        bus(0, `SEL_CTRL, 8'h09);
        d = 8'($urandom);
        pport_peer_inst.send(d);
        for (k = 0; k < 10 && in_full !== 1'b1; k++) cyc(1);
        check("in_full", 8'(in_full), 8'h01);
        check("in_irq", 8'(a_irq), 8'h01);
        i = d;
        bus(1, `SEL_PORT_C, 8'h00);
        check("status_in", d & 8'h38, 8'h38);
        bus(1, `SEL_PORT_A, 8'h00);
        check("in_byte", d, 8'(i));
        cyc(1);
        check("in_clr", 8'(in_full), 8'h00);
        check("in_irq_clr", 8'(a_irq), 8'h00);
        bus(0, `SEL_PORT_A, 8'hC3);
        for (k = 0; k < 20 && a_oe !== 1'b1; k++) cyc(1);
        check("bidir_out", a_oe ? a_o : 8'h00, 8'hC3);
        $display("test bidir done");
        stop_test;
    end
endmodule // testbench
